// File: e3_overhead_insert_port.sv
// Purpose : Transmit overhead insertion port of an E3 framer channel (pulse counting).
// Assumes : Terminal holds request and data from one strobe until the next.
// Notes   : A request seen at a strobe applies to the slot of the previous strobe
//           and is used when that slot comes round in the next frame.
`timescale 1ns/1ps
module e3_overhead_insert_port
#(
    parameter int BIT_DIV    = ovh_insert_pkg::BIT_DIV_DEF,
    parameter int ROW_BITS   = ovh_insert_pkg::ROW_BITS_DEF,
    parameter int FRAME_ROWS = ovh_insert_pkg::FRAME_ROWS_DEF
)
(
    // Clock and reset
    input  wire logic                                sys_clk,
    input  wire logic                                resetn,
    // Framer core side
    input  wire logic                                payloadBit,
    output logic                                     payloadTake,
    input  wire logic                                ovhOwnBit,
    output logic      [ovh_insert_pkg::OH_IDX_W-1:0] ovhOwnIndex,
    output logic                                     lineDataOut,
    output logic                                     lineDataValid,
    // Terminal overhead port
    output logic                                     ovhFrameMarker,
    output logic                                     ovhSlotStrobe,
    input  wire logic                                ovhInsertRequest,
    input  wire logic                                ovhSerialIn
);
    import ovh_insert_pkg::*;

    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BIT_DIV - 1);
    localparam logic [DIV_W-1:0] DIV_PRE  = DIV_W'(BIT_DIV - 2);
    localparam logic [COL_W-1:0] COL_LAST = COL_W'(ROW_BITS - 1);
    localparam logic [ROW_W-1:0] ROW_LAST = ROW_W'(FRAME_ROWS - 1);

    // ---------------------------------------------------------------
    // Bit timing and frame position
    // ---------------------------------------------------------------
    logic [DIV_W-1:0]    divCnt_reg;
    logic [DIV_W-1:0]    divCnt_next;
    logic [COL_W-1:0]    col_reg;
    logic [COL_W-1:0]    col_next;
    logic [ROW_W-1:0]    row_reg;
    logic [ROW_W-1:0]    row_next;
    logic                bitTick;
    logic                preTick;
    logic                slotIsOh;
    logic [OH_IDX_W-1:0] ohIdx;
    logic                slotInsertable;

    ovh_slot_map slotMap (
        .rowPos         (row_reg),
        .colPos         (col_reg),
        .slotIsOh       (slotIsOh),
        .ohIdx          (ohIdx),
        .slotInsertable (slotInsertable)
    );

    always_comb begin
        bitTick     = (divCnt_reg == DIV_LAST);
        preTick     = (divCnt_reg == DIV_PRE);
        divCnt_next = bitTick ? '0 : divCnt_reg + DIV_W'(1);
        col_next    = col_reg;
        row_next    = row_reg;
        if (bitTick) begin
            if (col_reg == COL_LAST) begin
                col_next = '0;
                row_next = (row_reg == ROW_LAST) ? '0 : row_reg + ROW_W'(1);
            end else begin
                col_next = col_reg + COL_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            divCnt_reg <= '0;
            col_reg    <= '0;
            row_reg    <= '0;
        end else begin
            divCnt_reg <= divCnt_next;
            col_reg    <= col_next;
            row_reg    <= row_next;
        end
    end

    // ---------------------------------------------------------------
    // Terminal strobes
    // ---------------------------------------------------------------
    always_comb begin
        ovhSlotStrobe  = preTick && slotIsOh;
        ovhFrameMarker = ovhSlotStrobe && (ohIdx == OH_FIRST_IDX);
        ovhOwnIndex    = ohIdx;
        payloadTake    = bitTick && !slotIsOh;
    end

    // ---------------------------------------------------------------
    // Insert capture and line output
    // ---------------------------------------------------------------
    logic [OH_COUNT-1:0] insValid_reg;
    logic [OH_COUNT-1:0] insValid_next;
    logic [OH_COUNT-1:0] insData_reg;
    logic [OH_COUNT-1:0] insData_next;
    logic [OH_IDX_W-1:0] lastIdx_reg;
    logic [OH_IDX_W-1:0] lastIdx_next;
    logic                haveLast_reg;
    logic                haveLast_next;
    logic                lineData_reg;
    logic                lineData_next;
    logic                lineValid_reg;
    logic                lineValid_next;
    logic                acceptInsert;

    always_comb begin
        insValid_next  = insValid_reg;
        insData_next   = insData_reg;
        lastIdx_next   = lastIdx_reg;
        haveLast_next  = haveLast_reg;
        lineData_next  = lineData_reg;
        lineValid_next = bitTick;
        // Request held since the previous strobe belongs to that slot
        acceptInsert   = ovhSlotStrobe && haveLast_reg && ovhInsertRequest
                         && slot_insertable(lastIdx_reg);
        if (acceptInsert) begin
            insValid_next[lastIdx_reg] = 1'b1;
            insData_next[lastIdx_reg]  = ovhSerialIn;
        end
        if (ovhSlotStrobe) begin
            lastIdx_next  = ohIdx;
            haveLast_next = 1'b1;
        end
        if (bitTick) begin
            if (slotIsOh) begin
                // Stored value is used once, then the slot reverts to own value
                lineData_next          = (slotInsertable && insValid_reg[ohIdx])
                                         ? insData_reg[ohIdx] : ovhOwnBit;
                insValid_next[ohIdx]   = 1'b0;
            end else begin
                lineData_next = payloadBit;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            insValid_reg  <= '0;
            insData_reg   <= '0;
            lastIdx_reg   <= '0;
            haveLast_reg  <= 1'b0;
            lineData_reg  <= 1'b0;
            lineValid_reg <= 1'b0;
        end else begin
            insValid_reg  <= insValid_next;
            insData_reg   <= insData_next;
            lastIdx_reg   <= lastIdx_next;
            haveLast_reg  <= haveLast_next;
            lineData_reg  <= lineData_next;
            lineValid_reg <= lineValid_next;
        end
    end

    always_comb begin
        lineDataOut   = lineData_reg;
        lineDataValid = lineValid_reg;
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    chk_strobe_one_cycle: assert property (ovhSlotStrobe |=> !ovhSlotStrobe)
        else $error("slot strobe longer than one clock");
    chk_strobe_before_oh: assert property (ovhSlotStrobe |=> (bitTick && slotIsOh))
        else $error("strobe not followed by overhead bit");
    chk_marker_first_bit: assert property (ovhFrameMarker |-> (ovhSlotStrobe && ohIdx == 6'h00))
        else $error("frame marker off the first overhead bit");
    chk_first_has_marker: assert property ((ovhSlotStrobe && ohIdx == 6'h00) |-> ovhFrameMarker)
        else $error("first overhead bit without frame marker");
    chk_first_bit_taken: assert property ((ovhSlotStrobe && haveLast_reg && lastIdx_reg == 6'h00
        && ovhInsertRequest) |=> (insValid_reg[0] && insData_reg[0] == $past(ovhSerialIn)))
        else $error("insert at count zero not stored");
    chk_align_refused: assert property ((ovhSlotStrobe && haveLast_reg && lastIdx_reg >= 6'h01
        && lastIdx_reg <= 6'h17) |=> (insValid_reg == $past(insValid_reg)))
        else $error("insert stored for refused position");
    chk_trail_taken: assert property ((ovhSlotStrobe && haveLast_reg && ovhInsertRequest
        && lastIdx_reg >= 6'h18 && lastIdx_reg <= 6'h1D)
        |=> insData_reg[$past(lastIdx_reg)] == $past(ovhSerialIn))
        else $error("trail trace insert not stored");
    chk_slot_order: assert property ((ovhSlotStrobe && haveLast_reg && ohIdx != 6'h00)
        |-> ohIdx == lastIdx_reg + 6'h01)
        else $error("overhead slots out of order");
    chk_refused_own_value: assert property ((bitTick && slotIsOh && !slotInsertable)
        |=> (lineDataValid && lineDataOut == $past(ovhOwnBit)))
        else $error("refused slot did not send own value");
    chk_inserted_sent: assert property ((bitTick && slotInsertable && insValid_reg[ohIdx])
        |=> (lineDataOut == $past(insData_reg[ohIdx]) && !insValid_reg[$past(ohIdx)]))
        else $error("stored insert not sent exactly once");
    chk_no_strobe_payload: assert property (payloadTake |-> !$past(ovhSlotStrobe))
        else $error("payload bit preceded by slot strobe");

    // ---------------------------------------------------------------
    // Strobe count since the last marker, as a terminal counts it
    // ---------------------------------------------------------------
    logic [OH_IDX_W-1:0] chkStrobes_reg;
    logic [OH_IDX_W-1:0] chkStrobes_next;
    logic                chkMarked_reg;
    logic                chkMarked_next;

    always_comb begin
        chkStrobes_next = chkStrobes_reg;
        chkMarked_next  = chkMarked_reg || ovhFrameMarker;
        if (ovhFrameMarker) begin
            chkStrobes_next = '0;
        end else if (ovhSlotStrobe) begin
            chkStrobes_next = chkStrobes_reg + OH_IDX_W'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            chkStrobes_reg <= '0;
            chkMarked_reg  <= 1'b0;
        end else begin
            chkStrobes_reg <= chkStrobes_next;
            chkMarked_reg  <= chkMarked_next;
        end
    end

    // Marker comes exactly after the last of the frame's overhead slots
    chk_frame_slot_count: assert property ((ovhSlotStrobe && chkMarked_reg)
        |-> (ovhFrameMarker == (chkStrobes_reg == OH_IDX_W'(OH_COUNT - 1))))
        else $error("frame marker after wrong number of strobes");

    cov_frame_marker: cover property (ovhFrameMarker);
    cov_insert_taken: cover property (acceptInsert);
    cov_insert_refused: cover property (ovhSlotStrobe && haveLast_reg && ovhInsertRequest
        && !slot_insertable(lastIdx_reg));
    cov_inserted_sent: cover property (bitTick && slotInsertable && insValid_reg[ohIdx]);

endmodule

// File: ovh_insert_pkg.sv
// Purpose : Shared constants for the E3 overhead bit insertion port.
// Assumes : One line bit is handled per bit tick; the tick comes from a clock divider.
// Notes   : Overhead bit index n is byte n/8 of the frame overhead, bit 7-(n%8).
//
// Notes on behaviour
// - Strobe high just before each overhead bit
// - Marker with strobe only for first overhead bit
// - Count zero is byte one bit 7, insertable
// - Counts 1 to 23 never insertable
// - Counts 24 to 55 insertable
// - Eight strobes per byte, MSB first
// - Strobe lasts exactly one clock
// - Refused insert ignored, own value sent
package ovh_insert_pkg;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_FREQ_KHZ   = 125000;
    localparam int LINE_RATE_KHZ  = 34368;
    localparam int BIT_DIV_DEF    = CLK_FREQ_KHZ / LINE_RATE_KHZ;
    localparam int DIV_W          = 8;

    // ---------------------------------------------------------------
    // Frame layout
    // ---------------------------------------------------------------
    localparam int ROW_BITS_DEF   = 537;
    localparam int FRAME_ROWS_DEF = 8;
    localparam int COL_W          = 10;
    localparam int ROW_W          = 4;
    localparam int OH_BYTES       = 7;
    localparam int BYTE_BITS      = 8;
    localparam int OH_COUNT       = 56;
    localparam int OH_IDX_W       = 6;

    // Bit n set: overhead bit with strobe count n accepts insertion
    localparam logic [OH_COUNT-1:0] OH_INSERTABLE = 56'hFFFFFFFF000001;
    localparam logic [OH_IDX_W-1:0] OH_FIRST_IDX  = 6'h00;

    function automatic logic slot_insertable(input logic [OH_IDX_W-1:0] idx);
        return OH_INSERTABLE[idx];
    endfunction

endpackage

// File: ovh_slot_map.sv
// Purpose : Maps a frame row and column to overhead slot index and insertability.
// Assumes : Overhead bytes occupy the first eight columns of rows 0 to 6.
// Notes   : Column 0 carries bit 7 of the byte, so bytes go out MSB first.
`timescale 1ns/1ps
module ovh_slot_map
(
    // Position of the next line bit
    input  wire logic [ovh_insert_pkg::ROW_W-1:0]    rowPos,
    input  wire logic [ovh_insert_pkg::COL_W-1:0]    colPos,
    // Slot decode
    output logic                                     slotIsOh,
    output logic      [ovh_insert_pkg::OH_IDX_W-1:0] ohIdx,
    output logic                                     slotInsertable
);
    import ovh_insert_pkg::*;

    always_comb begin
        slotIsOh       = (rowPos < ROW_W'(OH_BYTES)) && (colPos < COL_W'(BYTE_BITS));
        ohIdx          = {rowPos[2:0], colPos[2:0]};
        slotInsertable = slotIsOh && slot_insertable(ohIdx);
    end
endmodule

// File: ovh_terminal_model.sv
// Purpose : Terminal equipment that inserts overhead bits by counting strobes.
// Assumes : Marker and strobe come straight from the port under test.
// Notes   : With no request the data line toggles every cycle.
`timescale 1ns/1ps
module ovh_terminal_model (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // Port signals
    input  wire logic        ovhFrameMarker,
    input  wire logic        ovhSlotStrobe,
    input  wire logic [55:0] wantMask,
    input  wire logic [55:0] wantVal,
    output logic             ovhInsertRequest,
    output logic             ovhSerialIn
);
    int   cnt;
    int   nextCnt;
    logic hit;

    // -----------------------------------------------------------
    // Strobe counting and insertion
    // -----------------------------------------------------------
    always_comb begin
        nextCnt = ovhFrameMarker ? 0 : cnt + 1;
        hit     = (nextCnt < 56) && wantMask[nextCnt];
    end

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt              <= 0;
            ovhInsertRequest <= 1'b0;
            ovhSerialIn      <= 1'b0;
        end else if (ovhSlotStrobe) begin
            cnt              <= nextCnt;
            ovhInsertRequest <= #1 hit;
            ovhSerialIn      <= #1 hit ? wantVal[nextCnt] : ~ovhSerialIn;
        end else if (!ovhInsertRequest) begin
            ovhSerialIn <= #1 ~ovhSerialIn;
        end
    end
endmodule

// File: e3_overhead_insert_port_tb.sv
// Purpose : Self-checking bench for the overhead insertion port.
// Assumes : Short rows of 16 bits, 8 rows, 3 clocks per line bit.
// Notes   : Three runs: request everywhere, random requests, none.
`timescale 1ns/1ps
module e3_overhead_insert_port_tb;
    import ovh_insert_pkg::*;
    localparam int RB = 16;
    localparam int FB = RB * 8;
    logic sys_clk, resetn, payloadBit, ovhOwnBit, ovhInsertRequest, ovhSerialIn;
    logic payloadTake, lineDataOut, lineDataValid, ovhFrameMarker, ovhSlotStrobe;
    logic [55:0] wantMask, wantVal;
    logic lastOwn, lastPay, stbSeen, prevStb, oh, expBit, prevTake;
    logic [5:0] ownIdx;
    logic store[56];
    bit   pend[56];
    int   mismatches, n_compared, seed, pos, s, prevSlot;

    e3_overhead_insert_port #(.BIT_DIV(3), .ROW_BITS(RB), .FRAME_ROWS(8)) dut (
        .sys_clk(sys_clk), .resetn(resetn), .payloadBit(payloadBit),
        .payloadTake(payloadTake), .ovhOwnBit(ovhOwnBit), .ovhOwnIndex(ownIdx),
        .lineDataOut(lineDataOut), .lineDataValid(lineDataValid),
        .ovhFrameMarker(ovhFrameMarker), .ovhSlotStrobe(ovhSlotStrobe),
        .ovhInsertRequest(ovhInsertRequest), .ovhSerialIn(ovhSerialIn));
    ovh_terminal_model term (
        .sys_clk(sys_clk), .resetn(resetn), .ovhFrameMarker(ovhFrameMarker),
        .ovhSlotStrobe(ovhSlotStrobe), .wantMask(wantMask), .wantVal(wantVal),
        .ovhInsertRequest(ovhInsertRequest), .ovhSerialIn(ovhSerialIn));

    // -----------------------------------------------------------
    // Compare and closing tasks
    // -----------------------------------------------------------
    task automatic checkBit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t line bit %b expected %b", $time, got, exp);
        end
    endtask
    task automatic checkFlag(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t port flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic checkIndex(input logic [5:0] got, input logic [5:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t slot index %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        #1 {payloadBit, ovhOwnBit} = 2'($random(seed));
    end

    // Reference model: slot n sits at row n/8, column n%8 of the frame
    always @(posedge sys_clk) begin
        if (!resetn) begin
            pos = 0;
            prevSlot = -1;
            stbSeen = 1'b0;
            prevStb = 1'b0;
            foreach (pend[i]) pend[i] = 0;
        end else begin
            if (lineDataValid) begin
                oh = (pos / RB < 7) && (pos % RB < 8);
                s = (pos / RB) * 8 + pos % RB;
                checkFlag(stbSeen, oh);
                checkFlag(prevTake, !oh);
                expBit = !oh ? lastPay : (pend[s] ? store[s] : lastOwn);
                checkBit(lineDataOut, expBit);
                if (oh) pend[s] = 0;
                pos = (pos + 1) % FB;
                stbSeen = 1'b0;
            end
            if (ovhSlotStrobe) begin
                checkFlag(prevStb, 1'b0);
                checkFlag(ovhFrameMarker, pos == 0);
                if (prevSlot >= 0 && ovhInsertRequest && (prevSlot == 0 || prevSlot >= 24)) begin
                    store[prevSlot] = ovhSerialIn;
                    pend[prevSlot] = 1;
                end
                prevSlot = (pos / RB) * 8 + pos % RB;
                checkIndex(ownIdx, 6'(prevSlot));
                stbSeen = 1'b1;
            end
            prevStb = ovhSlotStrobe;
            lastOwn = ovhOwnBit;
            lastPay = payloadBit;
            prevTake = payloadTake;
        end
    end

    initial begin
        seed = 32'h9e3fc88e;
        mismatches = 0;
        n_compared = 0;
        resetn = 1'b0;
        for (int ph = 0; ph < 3; ph++) begin
            wantVal = 56'({$random(seed), $random(seed)});
            wantMask = (ph == 0) ? '1 : (ph == 1) ? 56'({$random(seed), $random(seed)}) : '0;
            repeat (8) @(posedge sys_clk);
            #1 resetn = 1'b1;
            repeat (4 * FB * 3) @(posedge sys_clk);
            #1 resetn = 1'b0;
        end
        conclude;
    end

    initial begin
        #100000;
        mismatches++;
        $display("ERROR %0t watchdog expired", $time);
        conclude;
    end
endmodule
